// ### epled_pkg.sv
package epled_pkg;

    // Register word addresses on the plain register port.
    localparam logic [4:0] ADDR_MODE_CTL   = 5'h10;
    localparam logic [4:0] ADDR_BEHAV_CTL  = 5'h11;
    localparam logic [4:0] ADDR_SIMPLE_CTL = 5'h1b;
    localparam logic [4:0] ADDR_MISC_CTL   = 5'h1e;
    localparam logic [4:0] ADDR_STATUS     = 5'h1f;

    // Behaviour register fields.
    localparam int BEHAV_COMBINE_LSB = 0;
    localparam int BEHAV_METHOD_BIT  = 4;
    localparam int BEHAV_STRETCH_LSB = 5;
    localparam int BEHAV_RATE_LSB    = 9;
    localparam int BEHAV_PULSING_BIT = 11;
    localparam int BEHAV_STRAP_LSB   = 12;

    // Simple method register fields: two bits per pin, then a rate field.
    localparam int SIMPLE_RATE_LSB = 8;
    localparam logic [1:0] SIMPLE_NORMAL = 2'h0;
    localparam logic [1:0] SIMPLE_OFF    = 2'h1;
    localparam logic [1:0] SIMPLE_ON     = 2'h2;
    localparam logic [1:0] SIMPLE_ACT    = 2'h3;

    localparam int MISC_TX_ONLY_BIT = 14;

    // Reset values.
    localparam logic [15:0] MODE_CTL_RESET   = 16'h8210;
    localparam logic [15:0] BEHAV_CTL_RESET  = 16'h000f;
    localparam logic [15:0] SIMPLE_CTL_RESET = 16'h0000;
    localparam logic [15:0] MISC_CTL_RESET   = 16'h0000;

    // Display mode codes.
    localparam logic [3:0] MODE_LINK_ACT    = 4'h0;
    localparam logic [3:0] MODE_L1000_ACT   = 4'h1;
    localparam logic [3:0] MODE_L100_ACT    = 4'h2;
    localparam logic [3:0] MODE_L10_ACT     = 4'h3;
    localparam logic [3:0] MODE_L100_1000   = 4'h4;
    localparam logic [3:0] MODE_L10_1000    = 4'h5;
    localparam logic [3:0] MODE_L10_100     = 4'h6;
    localparam logic [3:0] MODE_DUPLEX_COLL = 4'h8;
    localparam logic [3:0] MODE_COLLISION   = 4'h9;
    localparam logic [3:0] MODE_ACTIVITY    = 4'ha;
    localparam logic [3:0] MODE_ANEG_FAULT  = 4'hc;
    localparam logic [3:0] MODE_FORCE_OFF   = 4'he;
    localparam logic [3:0] MODE_FORCE_ON    = 4'hf;

    // Link speed codes on the speed input.
    localparam logic [1:0] SPEED_10   = 2'h0;
    localparam logic [1:0] SPEED_100  = 2'h1;
    localparam logic [1:0] SPEED_1000 = 2'h2;

    // Timing.
    localparam int CLK_HZ             = 40000000;
    localparam int MS_TICK_CYCLES     = CLK_HZ / 1000;
    localparam int BLINK_FAST_HZ      = 20;
    localparam int BLINK_HALF_MS      = 1000 / (2 * BLINK_FAST_HZ);
    localparam int STRETCH_SHORT_MS   = 50;
    localparam int PULSING_HZ         = 5000;
    localparam int PULSING_DUTY_PCT   = 20;
    localparam int PULSING_CYCLES     = CLK_HZ / PULSING_HZ;

    typedef enum logic [1:0] {
        STR_IDLE = 2'b00,
        STR_ON   = 2'b01,
        STR_OFF  = 2'b10
    } epled_str_e;

endpackage

// ### epled_driver.sv
`timescale 1ns/1ps
module epled_driver
    import epled_pkg::*;
#(
    parameter int LED_COUNT      = 4,
    parameter int MS_CYCLES      = MS_TICK_CYCLES,
    parameter int PULSING_PERIOD = PULSING_CYCLES
) (
    input  wire logic                   clk_sys,
    input  wire logic                   reset,
    input  wire logic [4:0]             reg_addr,
    input  wire logic [15:0]            reg_wdata,
    input  wire logic                   reg_write,
    input  wire logic                   reg_read,
    output      logic [15:0]            reg_rdata,
    input  wire logic                   link_up,
    input  wire logic [1:0]             link_speed,
    input  wire logic                   full_duplex,
    input  wire logic                   tx_activity,
    input  wire logic                   rx_activity,
    input  wire logic                   collision,
    input  wire logic                   aneg_fault,
    input  wire logic [4*LED_COUNT-1:0] config_strap_pins,
    output      logic [LED_COUNT-1:0]   led_n
);

    ////////////////////////////////////////////////////////////////////////////////
    localparam int MS_W    = $clog2(MS_CYCLES + 1);
    localparam int PULSE_W = $clog2(PULSING_PERIOD + 1);
    localparam logic [PULSE_W-1:0] PULSE_ON_CYC =
        PULSE_W'(PULSING_PERIOD * PULSING_DUTY_PCT / 100);
    localparam logic [8:0] BLINK_HALF = 9'(BLINK_HALF_MS);
    localparam logic [8:0] STR_BASE   = 9'(STRETCH_SHORT_MS);

    // Default pin functions under the simple method.
    localparam logic [15:0] SIMPLE_MODES = {MODE_DUPLEX_COLL, MODE_L100_ACT,
                                            MODE_L1000_ACT, MODE_LINK_ACT};

    generate
        if (LED_COUNT < 1 || LED_COUNT > 4) begin : g_bad_count
            $error("LED_COUNT must be 1 to 4");
        end
        if (MS_CYCLES < 1 || PULSING_PERIOD < 5) begin : g_bad_timing
            $error("timing counts too small");
        end
    endgenerate

    typedef struct packed {
        logic                              strap_taken;
        logic [15:0]                       strap_modes;
        logic [15:0]                       mode_ctl;
        logic [15:0]                       behav_ctl;
        logic [15:0]                       simple_ctl;
        logic [15:0]                       misc_ctl;
        logic [15:0]                       rd_data;
        logic [MS_W-1:0]                   ms_cnt;
        logic [8:0]                        blink_cnt;
        logic                              blink_phase;
        logic [PULSE_W-1:0]                pulse_cnt;
        logic [LED_COUNT-1:0][8:0]         str_cnt;
        epled_str_e [LED_COUNT-1:0]        str_ph;
        logic [LED_COUNT-1:0]              led_n;
    } epled_state_s;

    epled_state_s state;
    epled_state_s next_state;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic        ms_tick;
        logic        enhanced;
        logic        tx_only;
        logic [1:0]  rate;
        logic [8:0]  blink_half;
        logic [8:0]  str_len;
        logic [2:0]  speed_hot;
        logic        activity;
        logic [3:0]  mode;
        logic        combine;
        logic        use_stretch;
        logic        steady;
        logic        event_hit;
        logic        ev_mode;
        logic        ind;
        logic        pulse_gate;
        logic [1:0]  simple_sel;
        ms_tick     = 1'b0;
        enhanced    = 1'b0;
        tx_only     = 1'b0;
        rate        = 2'h0;
        blink_half  = 9'h0;
        str_len     = 9'h0;
        speed_hot   = 3'h0;
        activity    = 1'b0;
        mode        = 4'h0;
        combine     = 1'b0;
        use_stretch = 1'b0;
        steady      = 1'b0;
        event_hit   = 1'b0;
        ev_mode     = 1'b0;
        ind         = 1'b0;
        pulse_gate  = 1'b1;
        simple_sel  = 2'h0;
        next_state  = state;

        // Straps are caught once, in the first cycle after reset is released.
        if (!state.strap_taken) begin
            next_state.strap_taken = 1'b1;
            next_state.strap_modes = 16'h0;
            next_state.strap_modes[4*LED_COUNT-1:0] = config_strap_pins;
        end

        // Register port. Unmapped reads return zero.
        if (reg_write) begin
            case (reg_addr)
                ADDR_MODE_CTL:   next_state.mode_ctl   = reg_wdata;
                ADDR_BEHAV_CTL:  next_state.behav_ctl  = reg_wdata;
                ADDR_SIMPLE_CTL: next_state.simple_ctl = reg_wdata;
                ADDR_MISC_CTL:   next_state.misc_ctl   = reg_wdata;
                default:         ;
            endcase
        end
        next_state.rd_data = 16'h0;
        if (reg_read) begin
            case (reg_addr)
                ADDR_MODE_CTL:   next_state.rd_data = state.mode_ctl;
                ADDR_BEHAV_CTL:  next_state.rd_data = state.behav_ctl;
                ADDR_SIMPLE_CTL: next_state.rd_data = state.simple_ctl;
                ADDR_MISC_CTL:   next_state.rd_data = state.misc_ctl;
                ADDR_STATUS: begin
                    next_state.rd_data[LED_COUNT-1:0] = ~state.led_n;
                    next_state.rd_data[4] = state.behav_ctl[BEHAV_METHOD_BIT];
                    next_state.rd_data[5] = state.blink_phase;
                end
                default:         next_state.rd_data = 16'h0;
            endcase
        end

        // Millisecond prescaler, independent of link speed.
        if (state.ms_cnt == '0) begin
            ms_tick = 1'b1;
            next_state.ms_cnt = MS_W'(MS_CYCLES - 1);
        end else begin
            next_state.ms_cnt = state.ms_cnt - 1'b1;
        end

        if (state.pulse_cnt >= PULSE_W'(PULSING_PERIOD - 1)) begin
            next_state.pulse_cnt = '0;
        end else begin
            next_state.pulse_cnt = state.pulse_cnt + 1'b1;
        end

        enhanced = state.behav_ctl[BEHAV_METHOD_BIT];
        tx_only  = state.misc_ctl[MISC_TX_ONLY_BIT];
        if (enhanced) begin
            rate = state.behav_ctl[BEHAV_RATE_LSB +: 2];
        end else begin
            rate = state.simple_ctl[SIMPLE_RATE_LSB +: 2];
        end
        // Rate code 0 is the fastest blink and the shortest stretch.
        blink_half = BLINK_HALF << rate;
        str_len    = STR_BASE << rate;

        if (ms_tick) begin
            if (state.blink_cnt >= blink_half - 9'h1) begin
                next_state.blink_cnt   = 9'h0;
                next_state.blink_phase = ~state.blink_phase;
            end else begin
                next_state.blink_cnt = state.blink_cnt + 9'h1;
            end
        end

        speed_hot[0] = link_up && (link_speed == SPEED_10);
        speed_hot[1] = link_up && (link_speed == SPEED_100);
        speed_hot[2] = link_up && (link_speed == SPEED_1000);
        activity = tx_activity || rx_activity;

        for (int i = 0; i < LED_COUNT; i++) begin
            if (enhanced) begin
                if (state.behav_ctl[BEHAV_STRAP_LSB + i]) begin
                    mode = state.strap_modes[4*i +: 4];
                end else begin
                    mode = state.mode_ctl[4*i +: 4];
                end
                combine     = state.behav_ctl[BEHAV_COMBINE_LSB + i];
                use_stretch = state.behav_ctl[BEHAV_STRETCH_LSB + i];
                pulse_gate  = !state.behav_ctl[BEHAV_PULSING_BIT] ||
                              (state.pulse_cnt < PULSE_ON_CYC);
            end else begin
                simple_sel = state.simple_ctl[2*i +: 2];
                case (simple_sel)
                    SIMPLE_OFF: mode = MODE_FORCE_OFF;
                    SIMPLE_ON:  mode = MODE_FORCE_ON;
                    SIMPLE_ACT: mode = MODE_ACTIVITY;
                    default:    mode = SIMPLE_MODES[4*i +: 4];
                endcase
                combine     = 1'b1;
                use_stretch = 1'b0;
                pulse_gate  = 1'b1;
            end

            case (mode)
                MODE_LINK_ACT: steady = |speed_hot;
                MODE_L1000_ACT: steady = speed_hot[2];
                MODE_L100_ACT: steady = speed_hot[1];
                MODE_L10_ACT: steady = speed_hot[0];
                MODE_L100_1000: steady = speed_hot[1] || speed_hot[2];
                MODE_L10_1000: steady = speed_hot[0] || speed_hot[2];
                MODE_L10_100: steady = speed_hot[0] || speed_hot[1];
                MODE_DUPLEX_COLL: steady = link_up && full_duplex;
                MODE_ANEG_FAULT: steady = aneg_fault;
                MODE_FORCE_ON: steady = 1'b1;
                default: steady = 1'b0;
            endcase

            case (mode)
                MODE_LINK_ACT, MODE_L1000_ACT, MODE_L100_ACT, MODE_L10_ACT,
                MODE_L100_1000, MODE_L10_1000, MODE_L10_100:
                    event_hit = combine && steady && activity;
                MODE_DUPLEX_COLL:
                    event_hit = combine && link_up && !full_duplex && collision;
                MODE_COLLISION: event_hit = collision;
                MODE_ACTIVITY: event_hit = tx_only ? tx_activity : activity;
                default: event_hit = 1'b0;
            endcase

            // Stretch runs a full on period and then a full off period, so short
            // bursts stay visible and a busy link still shows gaps.
            case (state.str_ph[i])
                STR_IDLE: begin
                    if (use_stretch && event_hit) begin
                        next_state.str_ph[i]  = STR_ON;
                        next_state.str_cnt[i] = str_len;
                    end
                end
                STR_ON: begin
                    if (ms_tick) begin
                        if (state.str_cnt[i] == 9'h0) begin
                            next_state.str_ph[i]  = STR_OFF;
                            next_state.str_cnt[i] = str_len;
                        end else begin
                            next_state.str_cnt[i] = state.str_cnt[i] - 9'h1;
                        end
                    end
                end
                STR_OFF: begin
                    if (ms_tick) begin
                        if (state.str_cnt[i] == 9'h0) begin
                            next_state.str_ph[i] = STR_IDLE;
                        end else begin
                            next_state.str_cnt[i] = state.str_cnt[i] - 9'h1;
                        end
                    end
                end
                default: next_state.str_ph[i] = STR_IDLE;
            endcase

            // Blinking or stretching flips the steady level, so a lit link
            // LED blinks off and a dark activity LED blinks on.
            // Only modes with a secondary event may be flipped, so a stretch left
            // running by an earlier mode cannot darken a forced or fault LED.
            ev_mode = (mode <= MODE_L10_100) ||
                      (mode >= MODE_DUPLEX_COLL && mode <= MODE_ACTIVITY);
            if (use_stretch) begin
                ind = steady ^ (ev_mode && state.str_ph[i] == STR_ON);
            end else begin
                ind = steady ^ (event_hit && state.blink_phase);
            end
            next_state.led_n[i] = ~(ind && pulse_gate);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state.strap_taken <= 1'b0;
            state.strap_modes <= 16'h0;
            state.mode_ctl    <= MODE_CTL_RESET;
            state.behav_ctl   <= BEHAV_CTL_RESET;
            state.simple_ctl  <= SIMPLE_CTL_RESET;
            state.misc_ctl    <= MISC_CTL_RESET;
            state.rd_data     <= 16'h0;
            state.ms_cnt      <= '0;
            state.blink_cnt   <= 9'h0;
            state.blink_phase <= 1'b0;
            state.pulse_cnt   <= '0;
            state.str_cnt     <= '0;
            state.str_ph      <= {LED_COUNT{STR_IDLE}};
            state.led_n       <= '1;
        end else begin
            state <= next_state;
        end
    end

    assign reg_rdata = state.rd_data;
    assign led_n     = state.led_n;

endmodule // epled_driver

// ### epled_driver_assertions.sv
`timescale 1ns/1ps
module epled_chk
    import epled_pkg::*;
#(
    parameter int LED_COUNT      = 4,
    parameter int MS_CYCLES      = MS_TICK_CYCLES,
    parameter int PULSING_PERIOD = PULSING_CYCLES
) (
    input wire logic                   clk_sys,
    input wire logic                   reset,
    input wire logic [4:0]             reg_addr,
    input wire logic [15:0]            reg_wdata,
    input wire logic                   reg_write,
    input wire logic                   reg_read,
    input wire logic [15:0]            reg_rdata,
    input wire logic                   link_up,
    input wire logic [1:0]             link_speed,
    input wire logic                   full_duplex,
    input wire logic                   tx_activity,
    input wire logic                   rx_activity,
    input wire logic                   collision,
    input wire logic                   aneg_fault,
    input wire logic [4*LED_COUNT-1:0] config_strap_pins,
    input wire logic [LED_COUNT-1:0]   led_n
);
    // Shadow copies of the mode, behaviour and simple registers, kept from the bus traffic alone.
    logic [15:0] sh_mode;
    logic [15:0] sh_behav;
    logic [15:0] sh_simple;
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sh_mode   <= MODE_CTL_RESET;
            sh_behav  <= BEHAV_CTL_RESET;
            sh_simple <= SIMPLE_CTL_RESET;
        end else if (reg_write) begin
            if (reg_addr == ADDR_MODE_CTL) sh_mode <= reg_wdata;
            if (reg_addr == ADDR_BEHAV_CTL) sh_behav <= reg_wdata;
            if (reg_addr == ADDR_SIMPLE_CTL) sh_simple <= reg_wdata;
        end
    end
    wire enh  = sh_behav[BEHAV_METHOD_BIT];
    wire own0 = enh && !sh_behav[BEHAV_STRAP_LSB] && !sh_behav[BEHAV_PULSING_BIT];
    wire f_off = own0 && sh_mode[3:0] == MODE_FORCE_OFF;
    wire f_on  = own0 && sh_mode[3:0] == MODE_FORCE_ON;
    wire f_res = own0 && sh_mode[3:0] == 4'h7;
    wire f_strap = enh && sh_behav[BEHAV_STRAP_LSB] && !sh_behav[BEHAV_PULSING_BIT]
                   && config_strap_pins[3:0] == MODE_FORCE_ON;
    wire f_simp  = !enh && sh_simple[1:0] == SIMPLE_ON;
    wire f_pulse = enh && sh_behav[BEHAV_PULSING_BIT] && !sh_behav[BEHAV_STRAP_LSB]
                   && sh_mode[3:0] == MODE_FORCE_ON;
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    property p_reset_dark; $fell(reset) |-> led_n == '1; endproperty
    a_reset_dark: assert property (p_reset_dark)
        else $error("LED lit straight after reset");
    property p_force_off; f_off && $past(f_off) |-> led_n[0]; endproperty
    a_force_off: assert property (p_force_off)
        else $error("forced-off LED is lit");
    property p_force_on; f_on && $past(f_on) |-> !led_n[0]; endproperty
    a_force_on: assert property (p_force_on)
        else $error("forced-on LED is dark");
    property p_reserved; f_res && $past(f_res) |-> led_n[0]; endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved mode lit the LED");
    property p_strap; f_strap && $past(f_strap) |-> !led_n[0]; endproperty
    a_strap: assert property (p_strap)
        else $error("strap mode not applied");
    property p_simple_on; f_simp && $past(f_simp) |-> !led_n[0]; endproperty
    a_simple_on: assert property (p_simple_on)
        else $error("simple method on setting ignored");
    property p_pulse; f_pulse && $past(f_pulse) |-> ##[1:PULSING_PERIOD] led_n[0]; endproperty
    a_pulse: assert property (p_pulse)
        else $error("pulsed LED held on for a whole period");
    property p_behav_rd;
        $past(reg_read) && $past(reg_addr) == ADDR_BEHAV_CTL |-> reg_rdata == $past(sh_behav);
    endproperty
    a_behav_rd: assert property (p_behav_rd)
        else $error("behaviour register read back wrong");
    property p_mode_rd;
        $past(reg_read) && $past(reg_addr) == ADDR_MODE_CTL |-> reg_rdata == $past(sh_mode);
    endproperty
    a_mode_rd: assert property (p_mode_rd)
        else $error("mode register read back wrong");
    c_pulse: cover property (f_pulse);
    c_strap: cover property (f_strap);
    c_reserved: cover property (f_res);
endmodule // epled_chk

// ### epled_board.sv
`timescale 1ns/1ps
// Each LED hangs from the supply with its cathode on a pin, so a low pin lights it.
module epled_board
    import epled_pkg::*;
#(
    parameter int LED_COUNT = 4
) (
    input  wire logic [LED_COUNT-1:0] led_n,
    output      logic [LED_COUNT-1:0] lit
);
    assign lit = ~led_n;
endmodule // epled_board

// ### tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin \
    checks++; \
    if ((got) !== (exp)) begin \
        err_count++; \
        $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); \
    end \
end
module tb_top
    import epled_pkg::*;
;
    // Short counts keep the slowest stretch setting to a few thousand cycles.
    localparam int MS = 10;
    localparam int PER = 10;
    localparam logic [20:0] MASK = {3'b011, 3'b101, 3'b110, 3'b001, 3'b010, 3'b100, 3'b111};
    logic        clk_sys, reset, reg_write, reg_read, link_up, full_duplex;
    logic        tx_activity, rx_activity, collision, aneg_fault;
    logic [4:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, config_strap_pins;
    logic [1:0]  link_speed;
    logic [3:0]  led_n, lit;
    int          err_count, checks, cyc;
    epled_driver #(.LED_COUNT(4), .MS_CYCLES(MS), .PULSING_PERIOD(PER)) DUT (
        .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .link_up(link_up), .link_speed(link_speed), .full_duplex(full_duplex),
        .tx_activity(tx_activity), .rx_activity(rx_activity), .collision(collision),
        .aneg_fault(aneg_fault), .config_strap_pins(config_strap_pins), .led_n(led_n));
    epled_board #(.LED_COUNT(4)) board (.led_n(led_n), .lit(lit));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        if (err_count == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic do_reset();
        reset <= 1'b1;
        repeat (10) @(posedge clk_sys);
        reset <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        @(posedge clk_sys);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        @(negedge clk_sys);
        `CHK("read data", e, reg_rdata)
    endtask
    task automatic lit_is(input logic [3:0] e);
        repeat (4) @(posedge clk_sys);
        `CHK("lit", e, lit)
    endtask
    task automatic run_len(input logic v, output int n);
        n = 0;
        for (int i = 0; i < 9000 && lit[0] !== v; i++) @(posedge clk_sys);
        while (lit[0] === v && n < 9000) begin
            @(posedge clk_sys);
            n++;
        end
    endtask
    task automatic tog(input logic [3:0] m, input logic [15:0] bh, input logic [15:0] misc,
                       input logic [2:0] ev, input logic blink);
        int  n;
        logic p;
        wr(ADDR_MODE_CTL, {4{m}});
        wr(ADDR_BEHAV_CTL, bh);
        wr(ADDR_MISC_CTL, misc);
        {tx_activity, rx_activity, collision} <= ev;
        n = 0;
        p = lit[0];
        repeat (600) begin
            @(posedge clk_sys);
            n += int'(lit[0] !== p);
            p = lit[0];
        end
        {tx_activity, rx_activity, collision} <= 3'h0;
        `CHK("blinking", blink, n > 1)
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        link_up <= 1'b1;
        link_speed <= SPEED_1000;
        full_duplex <= 1'b1;
        rd(ADDR_MODE_CTL, MODE_CTL_RESET);
        rd(ADDR_BEHAV_CTL, BEHAV_CTL_RESET);
        rd(ADDR_SIMPLE_CTL, SIMPLE_CTL_RESET);
        rd(ADDR_MISC_CTL, MISC_CTL_RESET);
        rd(5'h05, 16'h0000);
        lit_is(4'b1011);
        rd(ADDR_STATUS, 16'h000b);
    endtask
    task automatic t_method();
        aneg_fault <= 1'b1;
        wr(ADDR_SIMPLE_CTL, 16'h0055);
        lit_is(4'b0000);
        wr(ADDR_SIMPLE_CTL, 16'h00aa);
        lit_is(4'b1111);
        wr(ADDR_MODE_CTL, 16'hc7fe);
        wr(ADDR_BEHAV_CTL, 16'h0010);
        lit_is(4'b1010);
        wr(ADDR_SIMPLE_CTL, 16'h0055);
        lit_is(4'b1010);
        wr(ADDR_MODE_CTL, 16'hc7f7);
        lit_is(4'b1010);
        wr(ADDR_BEHAV_CTL, 16'h1010);
        lit_is(4'b1011);
        aneg_fault <= 1'b0;
        lit_is(4'b0011);
        rd(ADDR_BEHAV_CTL, 16'h1010);
        wr(ADDR_BEHAV_CTL, 16'h0000);
        lit_is(4'b0000);
    endtask
    task automatic t_modes();
        wr(ADDR_BEHAV_CTL, 16'h0010);
        for (int m = 0; m < 7; m++) begin
            wr(ADDR_MODE_CTL, {4{4'(m)}});
            for (int s = 0; s < 3; s++) begin
                link_speed <= 2'(s);
                lit_is({4{MASK[m*3+s]}});
            end
        end
        link_up <= 1'b0;
        lit_is(4'h0);
        wr(ADDR_MODE_CTL, 16'h8888);
        link_up <= 1'b1;
        for (int d = 0; d < 2; d++) begin
            full_duplex <= d[0];
            lit_is({4{d[0]}});
        end
    endtask
    task automatic t_timing();
        int n;
        int lo;
        wr(ADDR_MODE_CTL, 16'haaaa);
        wr(ADDR_MISC_CTL, 16'h0000);
        rx_activity <= 1'b1;
        for (int r = 0; r < 4; r++) begin
            wr(ADDR_BEHAV_CTL, 16'h0010 | 16'(r << BEHAV_RATE_LSB));
            run_len(1'b1, n);
            run_len(1'b0, n);
            run_len(1'b1, n);
            `CHK("blink on", (25 << r) * MS, n)
            run_len(1'b0, n);
            `CHK("blink off", (25 << r) * MS, n)
        end
        rx_activity <= 1'b0;
        for (int r = 0; r < 4; r++) begin
            lo = (50 << r) * MS;
            wr(ADDR_BEHAV_CTL, 16'h0030 | 16'(r << BEHAV_RATE_LSB));
            repeat (2 * lo + 4 * MS + 20) @(posedge clk_sys);
            rx_activity <= 1'b1;
            @(posedge clk_sys);
            rx_activity <= 1'b0;
            run_len(1'b1, n);
            `CHK("stretch on", 1'b1, n >= lo && n <= lo + 2 * MS)
            rx_activity <= 1'b1;
            run_len(1'b0, n);
            rx_activity <= 1'b0;
            `CHK("stretch off", 1'b1, n >= lo && n <= lo + 2 * MS + 20)
        end
    endtask
    task automatic t_pulse();
        int n;
        wr(ADDR_MODE_CTL, 16'hffff);
        lit_is(4'hf);
        wr(ADDR_BEHAV_CTL, 16'h0810);
        repeat (4) @(posedge clk_sys);
        n = 0;
        repeat (10 * PER) begin
            @(posedge clk_sys);
            n += int'(lit[0] === 1'b1);
        end
        `CHK("pulse lit", (PER * PULSING_DUTY_PCT / 100) * 10, n)
        do_reset();
        lit_is(4'b0011);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 90000) begin
            err_count++;
            conclude();
        end
    end
    initial begin
        {reset, reg_write, reg_read, link_up, full_duplex} = 5'h10;
        {tx_activity, rx_activity, collision, aneg_fault} = 4'h0;
        reg_addr = 5'h00;
        reg_wdata = 16'h0000;
        link_speed = SPEED_10;
        config_strap_pins = 16'h000f;
        do_reset();
        t_reset();
        t_method();
        t_modes();
        full_duplex <= 1'b0;
        tog(4'h0, 16'h0010, 16'h0000, 3'b010, 1'b0);
        tog(4'h0, 16'h001f, 16'h0000, 3'b010, 1'b1);
        tog(4'h0, 16'h001f, 16'h0000, 3'b100, 1'b1);
        tog(4'h0, 16'h001f, 16'h0000, 3'b000, 1'b0);
        tog(4'h8, 16'h001f, 16'h0000, 3'b001, 1'b1);
        tog(4'h9, 16'h0010, 16'h0000, 3'b001, 1'b1);
        wr(ADDR_SIMPLE_CTL, 16'h0003);
        tog(4'h0, 16'h0000, 16'h0000, 3'b010, 1'b1);
        tog(4'ha, 16'h0010, 16'h4000, 3'b010, 1'b0);
        tog(4'ha, 16'h0010, 16'h4000, 3'b100, 1'b1);
        t_timing();
        t_pulse();
        conclude();
    end
endmodule // tb_top
bind epled_driver epled_chk #(.LED_COUNT(LED_COUNT), .MS_CYCLES(MS_CYCLES),
    .PULSING_PERIOD(PULSING_PERIOD)) chk (.clk_sys(clk_sys), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .link_up(link_up), .link_speed(link_speed),
    .full_duplex(full_duplex), .tx_activity(tx_activity), .rx_activity(rx_activity),
    .collision(collision), .aneg_fault(aneg_fault), .config_strap_pins(config_strap_pins),
    .led_n(led_n));
